//--- dv/dvo_formatter_tb_top.sv
// self-checking testbench for the dvi pixel output formatter
`timescale 1ns/1ps
`default_nettype none

module dvo_formatter_tb_top;
    import dvo_pkg::*;
    localparam int ACT = 100;
    logic clk, rst, link_clk, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic chip_sleep_n, driver_sleep_n, pix_stb, video_active_in;
    logic video_active, opc, main_oe, ctl1_oe, lad, lad_oe, ces, clr;
    dvo_pix_s pix_in, even_bus, odd_bus;
    dvo_sync_s sync_in, sync_out;
    int bad_count, checks_done;

    dvo_formatter #(.ACT_CYC(ACT)) DUT (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chip_sleep_n(chip_sleep_n),
        .driver_sleep_n(driver_sleep_n), .link_clk(link_clk),
        .pix_stb(pix_stb), .pix_in(pix_in),
        .video_active_in(video_active_in), .sync_in(sync_in),
        .even_pixel_bus(even_bus), .odd_pixel_bus(odd_bus),
        .video_active(video_active), .sync_out(sync_out),
        .output_pixel_clock(opc), .main_oe(main_oe), .ctl1_oe(ctl1_oe),
        .link_activity_detect(lad), .lad_oe(lad_oe));

    dvo_panel_model u_panel (
        .output_pixel_clock(opc), .capture_rising(ces),
        .even_pixel_bus(even_bus), .odd_pixel_bus(odd_bus),
        .video_active(video_active), .main_oe(main_oe), .clear(clr));

    // ========================================================
    // clocks
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #3;
        forever #16 link_clk = ~link_clk;
    end

    // ========================================================
    // helpers
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            test_done();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // mode changes only between frames, then let them cross
    task automatic wr_ctrl(input logic [2:0] v);
        apb(1'b1, DVO_ADDR_CTRL, {29'h0, v});
        ces = v[DVO_CTRL_CES];
        repeat (6) @(posedge link_clk);
    endtask

    function automatic logic [23:0] pv(input int i);
        return {8'h30 + i[7:0], 8'h20 + i[7:0], 8'h10 + i[7:0]};
    endfunction

    task automatic beat(input logic act, input logic [23:0] px,
                        input logic [4:0] sy);
        @(posedge link_clk);
        clr <= 1'b0;
        pix_stb <= 1'b1;
        video_active_in <= act;
        pix_in <= px;
        sync_in <= sy;
        @(posedge link_clk);
        pix_stb <= 1'b0;
    endtask

    task automatic line(input int n);
        @(posedge link_clk);
        clr <= 1'b1;
        repeat (4) beat(1'b0, 24'h0, 5'h15);
        for (int i = 0; i < n; i++) beat(1'b1, pv(i), 5'h15);
        repeat (8) beat(1'b0, 24'h0, 5'h0a);
    endtask

    // ========================================================
    // scenarios
    task automatic scen_regs;
        apb(1'b0, DVO_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk({rd[30:0], e}, 32'h1);
    endtask

    task automatic scen_one(input logic edge_hi);
        wr_ctrl({1'b0, edge_hi, 1'b0});
        line(6);
        chk(u_panel.cap_n, 6);
        for (int i = 0; i < 6; i++) begin
            chk(u_panel.cap_even[i], pv(i));
            chk(u_panel.cap_even[i][7:0], 8'h10 + i);
            chk(u_panel.cap_odd[i], 24'h0);
        end
        chk(even_bus, 24'h0);
        chk(odd_bus, 24'h0);
        chk(sync_out, 5'h0a);
    endtask

    task automatic scen_two;
        wr_ctrl(3'b011);
        line(7);
        chk(u_panel.cap_n, 3);
        for (int k = 0; k < 3; k++) begin
            chk(u_panel.cap_even[k], pv(2 * k));
            chk(u_panel.cap_odd[k], pv(2 * k + 1));
        end
        chk(lad, 1'b1);
        repeat (ACT + 20) @(posedge clk);
        chk(lad, 1'b0);
    endtask

    task automatic scen_gate;
        wr_ctrl(3'b110);
        line(2);
        chk(u_panel.cap_n, 2);
        chk(u_panel.cap_even[1], pv(1));
        repeat (6) begin
            beat(1'b0, 24'h0, 5'h03);
            chk(opc, 1'b0);
        end
        repeat (ACT + 20) @(posedge clk);
        chk(lad, 1'b0);
    endtask

    task automatic scen_sleep;
        @(posedge clk);
        driver_sleep_n <= 1'b0;
        repeat (8) @(posedge link_clk);
        chk({main_oe, ctl1_oe, lad_oe}, 3'b011);
        apb(1'b0, DVO_ADDR_STAT, 32'h0);
        chk(rd, 32'h4);
        driver_sleep_n <= 1'b1;
        chip_sleep_n <= 1'b0;
        repeat (8) @(posedge link_clk);
        chk({main_oe, ctl1_oe, lad_oe}, 3'b000);
        apb(1'b1, DVO_ADDR_CTRL, 32'h1);
        apb(1'b0, DVO_ADDR_CTRL, 32'h0);
        chk(rd, 32'h6);
        apb(1'b0, DVO_ADDR_STAT, 32'h0);
        chk(rd, 32'h2);
        chip_sleep_n <= 1'b1;
        repeat (10) @(posedge link_clk);
        chk({main_oe, ctl1_oe, lad_oe}, 3'b111);
    endtask

    // ========================================================
    // main sequence
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pix_stb, video_active_in, pix_in, sync_in, ces, clr} = '0;
        chip_sleep_n = 1'b1;
        driver_sleep_n = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge link_clk);
        scen_regs();
        scen_one(1'b1);
        scen_one(1'b0);
        scen_two();
        scen_gate();
        scen_sleep();
        test_done();
    end

    initial begin
        #900000;
        bad_count++;
        test_done();
    end
endmodule

`default_nettype wire

//--- dv/dvo_panel_model.sv
// display timing controller model that samples the formatter outputs
`timescale 1ns/1ps
`default_nettype none

module dvo_panel_model
    import dvo_pkg::*;
(
    input wire logic output_pixel_clock, // pixel clock from the formatter
    input wire logic capture_rising,     // panel strap, matches edge select
    input wire dvo_pix_s even_pixel_bus, // even pixel bus
    input wire dvo_pix_s odd_pixel_bus,  // odd pixel bus
    input wire logic video_active,       // data enable
    input wire logic main_oe,            // drivers on
    input wire logic clear               // restart capture list
);
    logic [23:0] cap_even [0:31];
    logic [23:0] cap_odd [0:31];
    int cap_n = 0;

    // ========================================================
    // capture
    // released buses carry nothing, so only driven data is taken
    task automatic grab;
        if (video_active === 1'b1 && main_oe === 1'b1 && cap_n < 32) begin
            cap_even[cap_n] = even_pixel_bus;
            cap_odd[cap_n] = odd_pixel_bus;
            cap_n++;
        end
    endtask

    always @(posedge output_pixel_clock) begin
        if (capture_rising) grab();
    end

    always @(negedge output_pixel_clock) begin
        if (!capture_rising) grab();
    end

    always @(posedge clear) begin
        cap_n = 0;
    end
endmodule

`default_nettype wire

//--- pkg/dvo_pkg.sv
// shared constants and carrier types for the dvi pixel output formatter
package dvo_pkg;

    // ========================================================================
    // apb register map
    localparam logic [7:0] DVO_ADDR_CTRL = 8'h00;
    localparam logic [7:0] DVO_ADDR_STAT = 8'h04;

    // ctrl fields
    localparam int DVO_CTRL_PPC = 0;
    localparam int DVO_CTRL_CES = 1;
    localparam int DVO_CTRL_PCF = 2;
    localparam logic [2:0] DVO_CTRL_RST = 3'h0;

    // status fields
    localparam int DVO_STAT_LAD = 0;
    localparam int DVO_STAT_CHIP_SLEEP = 1;
    localparam int DVO_STAT_DRV_SLEEP = 2;

    // ========================================================================
    // timing
    localparam int DVO_CLK_PERIOD_NS = 10;
    localparam int DVO_ACT_TIMEOUT_NS = 100000;
    // least time, rounded up to whole clk cycles
    localparam int DVO_ACT_TIMEOUT_CYC =
        (DVO_ACT_TIMEOUT_NS + DVO_CLK_PERIOD_NS - 1) / DVO_CLK_PERIOD_NS;
    localparam int DVO_ACT_CNT_W = 16;

    // ========================================================================
    // carriers
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } dvo_pix_s;

    typedef struct packed {
        logic panel_clock_format;
        logic clock_edge_select;
        logic pixels_per_clock_select;
    } dvo_ctrl_s;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic [2:0] user_control_lines;
    } dvo_sync_s;

endpackage

//--- rtl/dvo_formatter.sv
// dvi receiver pixel output formatter with apb control and status
`timescale 1ns/1ps
`default_nettype none

module dvo_formatter
    import dvo_pkg::*;
#(
    parameter int unsigned ACT_CYC = DVO_ACT_TIMEOUT_CYC
) (
    input wire logic clk,                    // system clock, 100 mhz
    input wire logic rst,                    // async reset, active high
    input wire logic psel,                   // apb select
    input wire logic penable,                // apb access phase
    input wire logic pwrite,                 // apb write
    input wire logic [7:0] paddr,            // apb byte address
    input wire logic [31:0] pwdata,          // apb write data
    output logic [31:0] prdata,              // apb read data
    output logic pready,                     // apb ready
    output logic pslverr,                    // apb error, unmapped address
    input wire logic chip_sleep_n,           // pin, whole-chip sleep, low
    input wire logic driver_sleep_n,         // pin, driver sleep, low
    input wire logic link_clk,               // recovered link clock
    input wire logic pix_stb,                // decoder pixel slot strobe
    input wire dvo_pix_s pix_in,             // decoded pixel
    input wire logic video_active_in,        // decoded data enable
    input wire dvo_sync_s sync_in,           // decoded syncs and controls
    output dvo_pix_s even_pixel_bus,         // even pixel out
    output dvo_pix_s odd_pixel_bus,          // odd pixel out
    output logic video_active,               // data enable out
    output dvo_sync_s sync_out,              // syncs and control lines out
    output logic output_pixel_clock,         // pixel clock out
    output logic main_oe,                    // enable, all but keep group
    output logic ctl1_oe,                    // enable, control line 1
    output logic link_activity_detect,       // link active flag out
    output logic lad_oe                      // enable, activity detect
);

    // ========================================================================
    // link-domain reset and pin synchronisers
    logic lrst_a_ff, lrst_ff;
    logic csl_l1_ff, csl_l2_ff, drv_l1_ff, drv_l2_ff;
    logic upd1_ff, upd2_ff, upd3_ff, upd_ff, nxt_upd;
    dvo_ctrl_s ctrl_l2_ff;
    dvo_ctrl_s ctrl_ff, nxt_ctrl;

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lrst_a_ff <= 1'b1;
            lrst_ff <= 1'b1;
        end else begin
            lrst_a_ff <= 1'b0;
            lrst_ff <= lrst_a_ff;
        end
    end

    // ctrl word taken whole once the write toggle has crossed;
    // a second write within three link cycles may tear it
    always_ff @(posedge link_clk or posedge lrst_ff) begin
        if (lrst_ff) begin
            csl_l1_ff <= 1'b0;
            csl_l2_ff <= 1'b0;
            drv_l1_ff <= 1'b0;
            drv_l2_ff <= 1'b0;
            upd1_ff <= 1'b0;
            upd2_ff <= 1'b0;
            upd3_ff <= 1'b0;
            ctrl_l2_ff <= DVO_CTRL_RST;
        end else begin
            csl_l1_ff <= chip_sleep_n;
            csl_l2_ff <= csl_l1_ff;
            drv_l1_ff <= driver_sleep_n;
            drv_l2_ff <= drv_l1_ff;
            upd1_ff <= upd_ff;
            upd2_ff <= upd1_ff;
            upd3_ff <= upd2_ff;
            ctrl_l2_ff <= (upd2_ff ^ upd3_ff) ? ctrl_ff : ctrl_l2_ff;
        end
    end

    // ========================================================================
    // link-domain formatter
    logic act_d_ff, nxt_act_d, par_ff, nxt_par, ck_ff, nxt_ck;
    logic act_ff, nxt_act, output_pixel_clock_ff, nxt_output_pixel_clock;
    logic moe_ff, nxt_moe, koe_ff, nxt_koe;
    dvo_pix_s pend_ff, nxt_pend, even_ff, nxt_even, odd_ff, nxt_odd;
    dvo_sync_s sync_ff, nxt_sync;
    logic awake, ppc, first, even_now, beat;

    always_comb begin
        awake = csl_l2_ff;
        ppc = ctrl_l2_ff.pixels_per_clock_select;
        first = video_active_in & ~act_d_ff;
        even_now = first | ~par_ff;
        beat = 1'b0;
        nxt_act_d = act_d_ff;
        nxt_par = par_ff;
        nxt_ck = ck_ff;
        nxt_act = act_ff;
        nxt_pend = pend_ff;
        nxt_even = even_ff;
        nxt_odd = odd_ff;
        nxt_sync = sync_ff;
        // asleep: inputs ignored, state frozen
        if (awake && pix_stb) begin
            nxt_act_d = video_active_in;
            // numbering restarts with the first active pixel
            nxt_par = video_active_in ? even_now : ~par_ff;
            // one beat per pixel, or per pair in two-pixel mode
            if (ppc) begin
                beat = video_active_in ? ~even_now : par_ff;
            end else begin
                beat = 1'b1;
            end
            if (video_active_in && ppc && even_now) begin
                nxt_pend = pix_in;
            end
            if (beat) begin
                nxt_act = video_active_in;
                if (video_active_in) begin
                    // struct keeps blue low, red high
                    nxt_even = ppc ? pend_ff : pix_in;
                    nxt_odd = ppc ? pix_in : '0;
                end else begin
                    // blanking carries sync and controls only
                    nxt_even = '0;
                    nxt_odd = '0;
                    nxt_sync = sync_in;
                end
            end
            // clock low from each beat, high half-way to the next
            nxt_ck = ppc ? ~beat : 1'b0;
        end else if (awake) begin
            nxt_ck = ppc ? ck_ff : 1'b1;
        end
        // data changes as the clock falls for rising capture, inverted for falling
        if (ctrl_l2_ff.panel_clock_format && !nxt_act) begin
            nxt_output_pixel_clock = 1'b0;
        end else begin
            nxt_output_pixel_clock = nxt_ck ^ ~ctrl_l2_ff.clock_edge_select;
        end
        nxt_moe = awake & drv_l2_ff;
        nxt_koe = awake;
    end

    always_ff @(posedge link_clk or posedge lrst_ff) begin
        if (lrst_ff) begin
            act_d_ff <= 1'b0;
            par_ff <= 1'b0;
            ck_ff <= 1'b0;
            act_ff <= 1'b0;
            output_pixel_clock_ff <= 1'b0;
            moe_ff <= 1'b0;
            koe_ff <= 1'b0;
            pend_ff <= '0;
            even_ff <= '0;
            odd_ff <= '0;
            sync_ff <= '0;
        end else begin
            act_d_ff <= nxt_act_d;
            par_ff <= nxt_par;
            ck_ff <= nxt_ck;
            act_ff <= nxt_act;
            output_pixel_clock_ff <= nxt_output_pixel_clock;
            moe_ff <= nxt_moe;
            koe_ff <= nxt_koe;
            pend_ff <= nxt_pend;
            even_ff <= nxt_even;
            odd_ff <= nxt_odd;
            sync_ff <= nxt_sync;
        end
    end

    assign even_pixel_bus = even_ff;
    assign odd_pixel_bus = odd_ff;
    assign video_active = act_ff;
    assign sync_out = sync_ff;
    assign output_pixel_clock = output_pixel_clock_ff;
    assign main_oe = moe_ff;
    assign ctl1_oe = koe_ff;

    // ========================================================================
    // system-domain activity monitor and apb slave
    logic va1_ff, va2_ff, va3_ff, cs1_ff, cs2_ff, dr1_ff, dr2_ff;
    logic [DVO_ACT_CNT_W-1:0] cnt_ff, nxt_cnt;
    logic lad_ff, nxt_lad, ladoe_ff, nxt_ladoe, toggle;
    logic rdy_ff, nxt_rdy, err_ff, nxt_err;
    logic [31:0] rd_ff, nxt_rd;
    logic acc, hit;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            va1_ff <= 1'b0;
            va2_ff <= 1'b0;
            va3_ff <= 1'b0;
            cs1_ff <= 1'b0;
            cs2_ff <= 1'b0;
            dr1_ff <= 1'b0;
            dr2_ff <= 1'b0;
        end else begin
            va1_ff <= act_ff;
            va2_ff <= va1_ff;
            va3_ff <= va2_ff;
            cs1_ff <= chip_sleep_n;
            cs2_ff <= cs1_ff;
            dr1_ff <= driver_sleep_n;
            dr2_ff <= dr1_ff;
        end
    end

    always_comb begin
        toggle = va2_ff ^ va3_ff;
        nxt_cnt = cnt_ff;
        nxt_lad = lad_ff;
        // a quiet enable for the full timeout means the link is gone
        if (toggle) begin
            nxt_cnt = '0;
            nxt_lad = 1'b1;
        end else if (cnt_ff >= DVO_ACT_CNT_W'(ACT_CYC)) begin
            nxt_lad = 1'b0;
        end else begin
            nxt_cnt = cnt_ff + 1'b1;
        end
        nxt_ladoe = cs2_ff;
        acc = psel & penable;
        hit = (paddr == DVO_ADDR_CTRL) || (paddr == DVO_ADDR_STAT);
        // one wait state keeps every apb output on a flop
        nxt_rdy = acc & ~rdy_ff;
        nxt_err = acc & ~rdy_ff & ~hit;
        nxt_rd = '0;
        if (acc && !rdy_ff && !pwrite) begin
            if (paddr == DVO_ADDR_CTRL) begin
                nxt_rd[2:0] = ctrl_ff;
            end else if (paddr == DVO_ADDR_STAT) begin
                nxt_rd[DVO_STAT_LAD] = lad_ff;
                nxt_rd[DVO_STAT_CHIP_SLEEP] = ~cs2_ff;
                nxt_rd[DVO_STAT_DRV_SLEEP] = ~dr2_ff;
            end
        end
        nxt_ctrl = ctrl_ff;
        nxt_upd = upd_ff;
        // writes are ignored while the chip sleeps
        if (acc && rdy_ff && pwrite && cs2_ff
                && paddr == DVO_ADDR_CTRL) begin
            nxt_ctrl.pixels_per_clock_select = pwdata[DVO_CTRL_PPC];
            nxt_ctrl.clock_edge_select = pwdata[DVO_CTRL_CES];
            nxt_ctrl.panel_clock_format = pwdata[DVO_CTRL_PCF];
            nxt_upd = ~upd_ff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
            lad_ff <= 1'b0;
            ladoe_ff <= 1'b0;
            rdy_ff <= 1'b0;
            err_ff <= 1'b0;
            rd_ff <= '0;
            ctrl_ff <= DVO_CTRL_RST;
            upd_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            lad_ff <= nxt_lad;
            ladoe_ff <= nxt_ladoe;
            rdy_ff <= nxt_rdy;
            err_ff <= nxt_err;
            rd_ff <= nxt_rd;
            ctrl_ff <= nxt_ctrl;
            upd_ff <= nxt_upd;
        end
    end

    assign prdata = rd_ff;
    assign pready = rdy_ff;
    assign pslverr = err_ff;
    assign link_activity_detect = lad_ff;
    assign lad_oe = ladoe_ff;

    // ========================================================================
    // assertions
    AST_ONE_PX_EVEN: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        (awake && pix_stb && !ppc && video_active_in)
        |=> (even_ff == $past(pix_in)) && act_ff)
        else $error("one-pixel mode did not put the pixel on even bus");

    AST_ODD_LOW: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        (awake && pix_stb && !ppc) |=> (odd_ff == '0))
        else $error("odd bus not low in one-pixel mode");

    AST_PAIR_OUT: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        (awake && pix_stb && ppc && video_active_in && !even_now)
        |=> (odd_ff == $past(pix_in)) && (even_ff == $past(pend_ff)))
        else $error("pair not presented together");

    AST_LINE_FIRST: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        (awake && pix_stb && ppc && video_active_in && !act_d_ff)
        |=> (pend_ff == $past(pix_in)) && par_ff)
        else $error("first pixel of line not taken as even");

    AST_CHIP_SLEEP: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        !csl_l2_ff |=> !moe_ff && !koe_ff)
        else $error("outputs enabled during chip sleep");

    AST_DRV_SLEEP: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        (csl_l2_ff && !drv_l2_ff) |=> !moe_ff && koe_ff)
        else $error("driver sleep enables wrong");

    AST_CLK_GATE: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        (!act_ff && $past(ctrl_l2_ff.panel_clock_format)) |-> !output_pixel_clock_ff)
        else $error("pixel clock not gated outside active video");

    AST_EDGE_SEL: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        (awake && pix_stb && !ppc && !ctrl_l2_ff.panel_clock_format)
        |=> (output_pixel_clock_ff == !$past(ctrl_l2_ff.clock_edge_select))
        and ((!pix_stb && awake) |=> (output_pixel_clock_ff == !$past(output_pixel_clock_ff))))
        else $error("pixel clock edge not placed mid-beat");

    AST_LAD_SET: assert property (
        @(posedge clk) disable iff (rst)
        toggle |=> lad_ff ##1 (lad_ff || $past(cnt_ff) != '0))
        else $error("activity detect not raised on enable toggle");

    AST_APB_ANSWER: assert property (
        @(posedge clk) disable iff (rst)
        (psel && penable && !rdy_ff) |=> rdy_ff ##1 !rdy_ff)
        else $error("apb answer not one cycle after access");

endmodule

`default_nettype wire
